// [core/oft_test_ctrl.sv]
`timescale 1ns/10ps
// Overview of operation
// - Test mode drives sample phase bus from override bits 4..0, bit 4 to MSB.
// - Test mode holds sample strobe at override bit 5, normal source ignored.
// - Test mode drives level compare output from override bit 6.
// - Test mode drives in-phase bus from override bits 16..7, bit 16 to MSB.
// - Test mode drives output valid flag from override bit 17.
// - Test mode drives local oscillator tick from override bit 18.
// - Test mode drives quadrature bus from bits 28..19; bits 31..29 reserved.
// - Bit 3 of destination 4 switches test mode on and off.
// - Any write to destination 9 captures the gain loop accumulator for readback.
module oft_test_ctrl
#(
  parameter int ACC_W = 32
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [2:0] ctrlAddr,
  input wire logic [7:0] ctrlDataIn,
  input wire logic wrStrobe,
  input wire logic rdActive,
  output logic [7:0] ctrlDataOut,
  output logic ctrlDataOe,
  input wire logic [4:0] normPhase,
  input wire logic normStrobe,
  input wire logic normLevel,
  input wire logic [9:0] normIBus,
  input wire logic [9:0] normQBus,
  input wire logic normValid,
  input wire logic normLoTick,
  input wire logic [ACC_W-1:0] gainAccum,
  output logic [4:0] sample_phase_out,
  output logic sample_phase_strobe,
  output logic level_compare_out,
  output logic [9:0] inphase_out_bus,
  output logic [9:0] quadrature_out_bus,
  output logic output_valid_flag,
  output logic local_osc_tick,
  output logic testModeEn
);
  import oft_pkg::*;

  localparam int ACC_BYTES = ACC_W / 8;
  // Reserved top of the override word, never stored
  localparam int RSV_W = 32 - OFT_OVR_USED_W;

  // Readback is byte addressed, so the accumulator must fill whole bytes
  if (ACC_W < 8 || ACC_W > 32 || (ACC_W % 8) != 0)
  begin : g_bad_width
    $error("ACC_W must be 8, 16, 24 or 32");
  end

  // Hold word is exactly one override register wide
  if (OFT_HOLD_BYTES != 4)
  begin : g_bad_hold
    $error("OFT_HOLD_BYTES must be 4 to fill the override word");
  end

  // Fields must tile bits 28..0 exactly, or a pin would show a neighbour's bit
  if (OFT_PHASE_W != 5 || OFT_BUS_W != 10
      || OFT_PHASE_LSB + OFT_PHASE_W != OFT_STROBE_BIT
      || OFT_STROBE_BIT + 1 != OFT_LEVEL_BIT
      || OFT_LEVEL_BIT + 1 != OFT_IBUS_LSB
      || OFT_IBUS_LSB + OFT_BUS_W != OFT_VALID_BIT
      || OFT_VALID_BIT + 1 != OFT_LOTICK_BIT
      || OFT_LOTICK_BIT + 1 != OFT_QBUS_LSB
      || OFT_QBUS_LSB + OFT_BUS_W != OFT_OVR_USED_W
      || OFT_OVR_USED_W > 32)
  begin : g_bad_layout
    $error("Override field layout does not fit the output pins");
  end

  // Byte lane pick shared by both halves of the read map
  // Lane base formed by concatenation, so no multiplier is inferred
  function automatic logic [7:0] pickByte(input logic [31:0] word, input logic [1:0] lane);
    logic [4:0] base;
    base = {lane, 3'b000};
    return word[base +: 8];
  endfunction

  // True for a transfer write naming the given destination
  function automatic logic destHit(input logic xfer, input logic [7:0] d, input logic [7:0] w);
    return xfer && (d == w);
  endfunction

  logic [31:0] holdWord;
  logic [31:0] overrideVal_r;
  logic [ACC_W-1:0] accCapture_r;
  logic holdWr;
  logic xferWr;
  logic [31:0] accWide;
  logic cfgWr;
  logic ovrWr;
  logic capWr;

  assign holdWr = wrStrobe && (ctrlAddr < OFT_ADDR_XFER);
  assign xferWr = wrStrobe && (ctrlAddr == OFT_ADDR_XFER);

  // Transfer decode, one strobe per destination
  assign cfgWr = destHit(xferWr, ctrlDataIn, OFT_DEST_CONFIG);
  assign ovrWr = destHit(xferWr, ctrlDataIn, OFT_DEST_OVERRIDE);
  assign capWr = destHit(xferWr, ctrlDataIn, OFT_DEST_CAPTURE);

  // Capture padded to the bus word; lanes past ACC_W read zero
  assign accWide = 32'(accCapture_r);

  oft_hold_buf #(.BYTES(OFT_HOLD_BYTES)) u_hold
  (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .wrEn(holdWr),
    .wrSel(ctrlAddr[1:0]),
    .wrByte(ctrlDataIn),
    .holdWord(holdWord)
  );

  // Test mode enable bit of the configuration destination
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      testModeEn <= OFT_TEST_EN_RST;
    end
    else if (cfgWr)
    begin
      testModeEn <= holdWord[OFT_TEST_EN_BIT];
    end
  end

  // Override store; reserved top bits never stored so they read zero
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      overrideVal_r <= OFT_OVERRIDE_RST;
    end
    else if (ovrWr)
    begin
      overrideVal_r <= {{RSV_W{1'b0}}, holdWord[OFT_OVR_USED_W-1:0]};
    end
  end

  // Snapshot of the accumulator; hold data in the transfer is don't care
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      accCapture_r <= '0;
    end
    else if (capWr)
    begin
      accCapture_r <= gainAccum;
    end
  end

  // Output selection registered so pins switch cleanly on the clock
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      sample_phase_out <= 5'h00;
      sample_phase_strobe <= 1'b0;
      level_compare_out <= 1'b0;
      inphase_out_bus <= 10'h000;
      quadrature_out_bus <= 10'h000;
      output_valid_flag <= 1'b0;
      local_osc_tick <= 1'b0;
    end
    else if (testModeEn)
    begin
      sample_phase_out <= overrideVal_r[OFT_PHASE_LSB +: OFT_PHASE_W];
      sample_phase_strobe <= overrideVal_r[OFT_STROBE_BIT];
      level_compare_out <= overrideVal_r[OFT_LEVEL_BIT];
      inphase_out_bus <= overrideVal_r[OFT_IBUS_LSB +: OFT_BUS_W];
      output_valid_flag <= overrideVal_r[OFT_VALID_BIT];
      local_osc_tick <= overrideVal_r[OFT_LOTICK_BIT];
      quadrature_out_bus <= overrideVal_r[OFT_QBUS_LSB +: OFT_BUS_W];
    end
    // Normal path; stored overrides stay put for the next enable
    else
    begin
      sample_phase_out <= normPhase;
      sample_phase_strobe <= normStrobe;
      level_compare_out <= normLevel;
      inphase_out_bus <= normIBus;
      output_valid_flag <= normValid;
      local_osc_tick <= normLoTick;
      quadrature_out_bus <= normQBus;
    end
  end

  // Read mux: low addresses give capture bytes, high ones override bytes
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrlDataOut <= OFT_BYTE_RST;
    end
    else if (rdActive)
    begin
      if (ctrlAddr < OFT_ADDR_RD_OVR)
      begin
        if (int'(ctrlAddr) < ACC_BYTES)
        begin
          ctrlDataOut <= pickByte(accWide, ctrlAddr[1:0]);
        end
        else
        begin
          ctrlDataOut <= OFT_BYTE_RST;
        end
      end
      else
      begin
        ctrlDataOut <= pickByte(overrideVal_r, ctrlAddr[1:0]);
      end
    end
  end

  // Bus driven only while the processor holds its read active
  assign ctrlDataOe = rdActive;
endmodule

// [core/oft_pkg.sv]
package oft_pkg;
  // Microprocessor port addresses
  localparam logic [2:0] OFT_ADDR_HOLD0 = 3'h0;
  localparam logic [2:0] OFT_ADDR_XFER = 3'h4;
  localparam logic [2:0] OFT_ADDR_RD_OVR = 3'h4;
  localparam int OFT_HOLD_BYTES = 4;

  // Destination addresses carried in a transfer write
  localparam logic [7:0] OFT_DEST_CONFIG = 8'h04;
  localparam logic [7:0] OFT_DEST_OVERRIDE = 8'h08;
  localparam logic [7:0] OFT_DEST_CAPTURE = 8'h09;

  // Field positions
  localparam int OFT_TEST_EN_BIT = 3;
  localparam int OFT_PHASE_LSB = 0;
  localparam int OFT_PHASE_W = 5;
  localparam int OFT_STROBE_BIT = 5;
  localparam int OFT_LEVEL_BIT = 6;
  localparam int OFT_IBUS_LSB = 7;
  localparam int OFT_BUS_W = 10;
  localparam int OFT_VALID_BIT = 17;
  localparam int OFT_LOTICK_BIT = 18;
  localparam int OFT_QBUS_LSB = 19;
  localparam int OFT_OVR_USED_W = 29;

  // Reset values
  localparam logic [31:0] OFT_OVERRIDE_RST = 32'h0000_0000;
  localparam logic OFT_TEST_EN_RST = 1'b0;
  localparam logic [7:0] OFT_BYTE_RST = 8'h00;
endpackage

// [core/oft_hold_buf.sv]
`timescale 1ns/10ps
// Byte-wide holding buffer assembling a 32-bit word from the 8-bit bus
module oft_hold_buf
#(
  parameter int BYTES = 4
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic wrEn,
  input wire logic [1:0] wrSel,
  input wire logic [7:0] wrByte,
  output logic [8*BYTES-1:0] holdWord
);
  import oft_pkg::*;

  // Two select bits reach at most four byte lanes
  if (BYTES < 1 || BYTES > 4)
  begin : g_bad_bytes
    $error("BYTES must lie between 1 and 4");
  end

  // Read data comes straight from the storage flops
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      holdWord <= '0;
    end
    else if (wrEn && (int'(wrSel) < BYTES))
    begin
      holdWord[8*wrSel +: 8] <= wrByte;
    end
  end
endmodule

// [verif/oft_checker.sv]
`timescale 1ns/10ps
// Port-level watch on override and pass-through behaviour
module oft_checker
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [2:0] ctrlAddr,
  input wire logic [7:0] ctrlDataIn,
  input wire logic wrStrobe,
  input wire logic rdActive,
  input wire logic [7:0] ctrlDataOut,
  input wire logic ctrlDataOe,
  input wire logic [9:0] normIBus,
  input wire logic [9:0] normQBus,
  input wire logic [4:0] sample_phase_out,
  input wire logic sample_phase_strobe,
  input wire logic level_compare_out,
  input wire logic [9:0] inphase_out_bus,
  input wire logic [9:0] quadrature_out_bus,
  input wire logic output_valid_flag,
  input wire logic local_osc_tick,
  input wire logic testModeEn
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Two test-mode cycles without writes: normal sources must not leak through
  sequence quiet;
    testModeEn && !wrStrobe ##1 testModeEn && !wrStrobe;
  endsequence
  AST_PH: assert property (quiet |=> $stable(sample_phase_out)) else $error("phase moved");
  AST_ST: assert property (quiet |=> $stable(sample_phase_strobe)) else $error("strobe");
  AST_LV: assert property (quiet |=> $stable(level_compare_out)) else $error("level");
  AST_IB: assert property (quiet |=> $stable(inphase_out_bus)) else $error("in-phase");
  AST_VL: assert property (quiet |=> $stable({output_valid_flag, local_osc_tick}))
    else $error("valid or tick moved");
  AST_QB: assert property (quiet |=> $stable(quadrature_out_bus)) else $error("quad");
  AST_PASS: assert property (!testModeEn |=> inphase_out_bus == $past(normIBus)
    && quadrature_out_bus == $past(normQBus)) else $error("normal path lost");
  AST_EN: assert property ($changed(testModeEn) |-> $past(wrStrobe)
    && $past(ctrlAddr) == 3'h4 && $past(ctrlDataIn) == 8'h04) else $error("mode change");
  // Read data lines enabled only during a read, and held once it ends
  AST_OE: assert property (ctrlDataOe == rdActive) else $error("enable off read");
  AST_RDH: assert property (!rdActive |=> $stable(ctrlDataOut))
    else $error("read data moved");
  cover property (quiet);
  cover property ($rose(testModeEn));
  cover property ($fell(testModeEn));
  cover property (rdActive ##1 !rdActive);
endmodule
bind oft_test_ctrl oft_checker chk (.*);

// [verif/oft_cpu_model.sv]
`timescale 1ns/10ps
// Processor on the control bus; lines released after a write carry inverted junk
module oft_cpu_model
(
  input wire logic clk_sys,
  input wire logic [7:0] ctrlDataOut,
  output logic [2:0] ctrlAddr = 3'h7,
  output logic [7:0] ctrlDataIn = 8'h00,
  output logic wrStrobe = 1'b0,
  output logic rdActive = 1'b0,
  output logic [7:0] rdByte = 8'h00
);
  // One-cycle write pulse
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    {ctrlAddr, ctrlDataIn, wrStrobe} <= {a, d, 1'b1};
    @(negedge clk_sys);
    {ctrlAddr, ctrlDataIn, wrStrobe} <= {~a, ~d, 1'b0};
  endtask
  // Read held over one rising edge; data taken at the next fall, where it stands
  task automatic rd(input logic [2:0] a);
    @(negedge clk_sys);
    {ctrlAddr, rdActive} <= {a, 1'b1};
    @(negedge clk_sys);
    rdByte = ctrlDataOut;
    rdActive <= 1'b0;
  endtask
endmodule

// [verif/oft_tb.sv]
`timescale 1ns/10ps
module testbench;
  import oft_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [28:0] norm = '0;
  logic [31:0] gainAccum = '0;
  logic [31:0] ovr, g, got;
  logic [32:0] q[$], e;
  int err_total = 0, checked = 0;
  event chk;
  wire [28:0] obs;
  wire [2:0] ad;
  wire [7:0] di, dq, rb;
  wire ws, ra;
  initial forever #12.5 clk_sys = ~clk_sys;
  oft_cpu_model cpu (.clk_sys, .ctrlDataOut(dq), .ctrlAddr(ad), .ctrlDataIn(di), .wrStrobe(ws),
    .rdActive(ra), .rdByte(rb));
  // Normal sources and outputs share the override word layout
  oft_test_ctrl DUT (.clk_sys, .resetn, .ctrlAddr(ad), .ctrlDataIn(di), .wrStrobe(ws),
    .rdActive(ra), .ctrlDataOut(dq), .ctrlDataOe(), .normPhase(norm[4:0]), .normStrobe(norm[5]),
    .normLevel(norm[6]), .normIBus(norm[16:7]), .normValid(norm[17]), .normLoTick(norm[18]),
    .normQBus(norm[28:19]), .gainAccum, .sample_phase_out(obs[4:0]),
    .sample_phase_strobe(obs[5]), .level_compare_out(obs[6]), .inphase_out_bus(obs[16:7]),
    .output_valid_flag(obs[17]), .local_osc_tick(obs[18]), .quadrature_out_bus(obs[28:19]),
    .testModeEn());
  // Oldest note against the outputs or the last read byte
  always @(chk)
  begin
    e = q.pop_front();
    got = e[32] ? {24'h0, rb} : {3'h0, obs};
    checked++;
    if (got !== e[31:0])
    begin
      err_total++;
      $display("Error %s exp %h got %h", e[32] ? "rdByte" : "outputs", e[31:0], got);
    end
  end
  // Monitor fires 1 ns after the edge, once registered outputs have settled
  task automatic note(input logic k, input logic [31:0] v);
    q.push_back({k, v});
    #1;
    ->chk;
  endtask
  task automatic outs(input logic [28:0] v);
    repeat (2) @(posedge clk_sys);
    note(1'b0, {3'h0, v});
  endtask
  task automatic rdn(input int i, input logic [31:0] w);
    cpu.rd(i[2:0]);
    note(1'b1, {24'h0, w[8*(i%4)+:8]});
  endtask
  task automatic load(input logic [31:0] w, input logic [7:0] dest);
    for (int i = 0; i < 4; i++) cpu.wr(i[2:0], w[8*i+:8]);
    cpu.wr(OFT_ADDR_XFER, dest);
  endtask
  task automatic conclude();
    $display("Mismatches %0d in %0d checks", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Run needs about 140 cycles; give up after more than five times that
  initial
  begin
    #20000 err_total++;
    conclude();
  end
  initial
  begin
    void'($urandom(32'h488d8b70));
    repeat (6) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (2)
    begin
      @(negedge clk_sys) norm = $urandom;
      ovr = $urandom;
      g = $urandom;
      outs(norm);
      load(ovr, OFT_DEST_OVERRIDE);
      outs(norm);
      load(32'h08, OFT_DEST_CONFIG);
      @(negedge clk_sys) norm = ~norm;
      outs(ovr[28:0]);
      for (int i = 4; i < 8; i++) rdn(i, ovr & 32'h1fff_ffff);
      // Accumulator held an extra cycle so either capture edge sees it
      @(negedge clk_sys) gainAccum = g;
      cpu.wr(OFT_ADDR_XFER, OFT_DEST_CAPTURE);
      @(negedge clk_sys) gainAccum = ~g;
      for (int i = 0; i < 4; i++) rdn(i, g);
      load(32'hf7, OFT_DEST_CONFIG);
      @(negedge clk_sys) norm = $urandom;
      outs(norm);
      rdn(4, ovr);
    end
    // Reset in mid-run with test mode on: mode and overrides must clear
    load(32'h08, OFT_DEST_CONFIG);
    @(negedge clk_sys) resetn = 1'b0;
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    @(negedge clk_sys) norm = $urandom;
    outs(norm);
    rdn(4, 32'h0);
    conclude();
  end
endmodule
